// ---- rtl/sfsf_pkg.sv ----
// package: register offsets, field positions, reset values and modes of the fault status bank
package sfsf_pkg;
  localparam logic [5:0]  SFSF_FRONT_END_OFFSET  = 6'h0D;
  localparam logic [5:0]  SFSF_SYSTEM_OFFSET     = 6'h0E;
  localparam logic [15:0] SFSF_FRONT_END_RESET   = 16'h8000;
  localparam logic [15:0] SFSF_SYSTEM_RESET      = 16'h0000;
  // front-end status field positions
  localparam int SFSF_FE_POWER_UP_BIT  = 15;
  localparam int SFSF_FE_DIAG_BIT      = 12;
  localparam int SFSF_FE_TEMP_BIT      = 11;
  localparam int SFSF_FE_AXIS_Z_BIT    = 10;
  localparam int SFSF_FE_AXIS_Y_BIT    = 9;
  localparam int SFSF_FE_AXIS_X_BIT    = 8;
  localparam int SFSF_FE_TRIM_BIT      = 1;
  localparam int SFSF_FE_REGULATOR_BIT = 0;
  // system status field positions
  localparam int SFSF_SYS_PIN_LEVEL_BIT = 15;
  localparam int SFSF_SYS_ATTN_DRV_BIT  = 14;
  localparam int SFSF_SYS_SOUT_DRV_BIT  = 13;
  localparam int SFSF_SYS_CHECK_BIT     = 12;
  localparam int SFSF_SYS_FRAME_BIT     = 11;
  localparam int SFSF_SYS_STATE_LSB     = 8;
  localparam int SFSF_SYS_OVER_BIT      = 5;
  localparam int SFSF_SYS_UNDER_BIT     = 4;
  localparam int SFSF_SYS_TEMP_LIM_BIT  = 3;
  localparam int SFSF_SYS_Z_LIM_BIT     = 2;
  localparam int SFSF_SYS_Y_LIM_BIT     = 1;
  localparam int SFSF_SYS_X_LIM_BIT     = 0;
  // read-clear flag masks; everything outside them reads zero or is a live field
  localparam logic [15:0] SFSF_FE_CLEAR_MASK  = 16'h9F03;
  localparam logic [15:0] SFSF_SYS_CLEAR_MASK = 16'h783F;
  // attention cause codes
  localparam logic [1:0] SFSF_CAUSE_NONE = 2'h0;
  localparam logic [1:0] SFSF_CAUSE_FE   = 2'h1;
  localparam logic [1:0] SFSF_CAUSE_SYS  = 2'h2;
  localparam logic [1:0] SFSF_CAUSE_BOTH = 2'h3;
  typedef enum logic [2:0] {
    SFSF_MODE_CONFIG     = 3'h0,
    SFSF_MODE_STANDBY    = 3'h1,
    SFSF_MODE_CONTINUOUS = 3'h2,
    SFSF_MODE_TRIGGERED  = 3'h3,
    SFSF_MODE_DUTY_ACT   = 3'h4,
    SFSF_MODE_DUTY_SLEEP = 3'h5,
    SFSF_MODE_SLEEP      = 3'h6
  } sfsf_mode_type;
endpackage : sfsf_pkg

// ---- rtl/sfsf_sync.sv ----
// two-flop synchroniser for pin feedback levels
`timescale 1ns/100ps
module sfsf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : sfsf_sync

// ---- rtl/sfsf_status_bank.sv ----
// front-end and system fault status registers with read-clear flags
`timescale 1ns/100ps
// Functional notes
// - power-up flag bit 15 of front-end status is 1 after power-on reset
// - reading front-end status clears the power-up flag
// - front-end self-test failure sets bit 12, cleared by read
// - temperature sensor self-test failure sets bit 11, cleared by read
// - Z, Y, X axis self-test failures set bits 10, 9, 8, read-clear
// - trim data error sets bit 1, cleared by read
// - regulator fault sets bit 0, cleared by read
// - system bit 15 returns current synchronised attention pin level
// - attention pin driven but not seen low sets bit 14
// - serial output mismatch with feedback while driving sets bit 13
// - check-code failure of a transaction sets bit 12
// - wrong clock edge count in a transaction sets bit 11
// - bits 10-8 report operating state code 0h to 6h
// - supply over-voltage in active or standby sets bit 5
// - supply under-voltage in active or standby sets bit 4
// - temperature threshold crossing sets bit 3
// - Z, Y, X field threshold crossings set bits 2, 1, 0
// - two-bit attention cause summarises which register has flags set
module sfsf_status_bank
  import sfsf_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // register read port
  input  wire logic        i_rd_strobe,
  input  wire logic [5:0]  i_rd_addr,
  output logic      [15:0] o_rd_data,
  output logic             o_rd_valid,
  // front-end fault events, one-cycle pulses
  input  wire logic        i_front_end_diag_fail,
  input  wire logic        i_temp_diag_fail,
  input  wire logic        i_axis_z_diag_fail,
  input  wire logic        i_axis_y_diag_fail,
  input  wire logic        i_axis_x_diag_fail,
  input  wire logic        i_trim_error,
  input  wire logic        i_regulator_fault_flag,
  // attention pin drive and feedback
  input  wire logic        i_attention_drive_low,
  input  wire logic        i_attention_pin_level,
  // serial output drive and feedback
  input  wire logic        i_serial_out_enable,
  input  wire logic        i_serial_out_value,
  input  wire logic        i_serial_out_pin,
  // serial framing events
  input  wire logic        i_check_code_error,
  input  wire logic        i_frame_error,
  // operating state and monitor events
  input  wire logic [2:0]  i_operating_state,
  input  wire logic        i_supply_over,
  input  wire logic        i_supply_under,
  input  wire logic        i_temp_limit_crossed,
  input  wire logic        i_z_field_limit_crossed,
  input  wire logic        i_y_field_limit_crossed,
  input  wire logic        i_x_field_limit_crossed,
  output logic      [1:0]  o_attention_cause
);
  logic [15:0]   front_end_flags;
  logic [15:0]   system_flags;
  logic [15:0]   next_front_end_flags;
  logic [15:0]   next_system_flags;
  logic [15:0]   fe_set;
  logic [15:0]   sys_set;
  logic [15:0]   fe_clear;
  logic [15:0]   sys_clear;
  logic [15:0]   fe_view;
  logic [15:0]   sys_view;
  logic [1:0]    pin_sync;
  logic          attention_pin_level;
  logic          serial_out_pin_sync;
  logic          attn_drive_d;
  logic          attn_drive_d2;
  logic          sout_en_d;
  logic          sout_en_d2;
  logic          sout_val_d;
  logic          sout_val_d2;
  logic          powered_active;
  logic          rd_fe;
  logic          rd_sys;
  sfsf_mode_type mode;

  // decode of a read to one register address
  function automatic logic sfsf_hit(input logic strobe, input logic [5:0] addr,
                                    input logic [5:0] offset);
    return strobe && (addr == offset);
  endfunction

  // pin feedback arrives from outside the clock domain
  sfsf_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_async  ({i_attention_pin_level, i_serial_out_pin}),
    .o_sync   (pin_sync)
  );

  assign attention_pin_level = pin_sync[1];
  assign serial_out_pin_sync = pin_sync[0];
  assign mode                = sfsf_mode_type'(i_operating_state);
  assign rd_fe               = sfsf_hit(i_rd_strobe, i_rd_addr, SFSF_FRONT_END_OFFSET);
  assign rd_sys              = sfsf_hit(i_rd_strobe, i_rd_addr, SFSF_SYSTEM_OFFSET);

  // drive commands delayed to line up with the two-flop feedback path
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      attn_drive_d  <= 1'b0;
      attn_drive_d2 <= 1'b0;
      sout_en_d     <= 1'b0;
      sout_en_d2    <= 1'b0;
      sout_val_d    <= 1'b0;
      sout_val_d2   <= 1'b0;
    end else begin
      attn_drive_d  <= i_attention_drive_low;
      attn_drive_d2 <= attn_drive_d;
      sout_en_d     <= i_serial_out_enable;
      sout_en_d2    <= sout_en_d;
      sout_val_d    <= i_serial_out_value;
      sout_val_d2   <= sout_val_d;
    end
  end

  // supply limits only count in active or standby operation
  always_comb begin
    unique case (mode)
      SFSF_MODE_STANDBY, SFSF_MODE_CONTINUOUS, SFSF_MODE_TRIGGERED,
      SFSF_MODE_DUTY_ACT: powered_active = 1'b1;
      SFSF_MODE_CONFIG, SFSF_MODE_DUTY_SLEEP, SFSF_MODE_SLEEP: powered_active = 1'b0;
      default: powered_active = 1'b0; // code 7h is not a state
    endcase
  end

  // front-end set terms
  always_comb begin
    fe_set                        = '0;
    fe_set[SFSF_FE_DIAG_BIT]      = i_front_end_diag_fail;
    fe_set[SFSF_FE_TEMP_BIT]      = i_temp_diag_fail;
    fe_set[SFSF_FE_AXIS_Z_BIT]    = i_axis_z_diag_fail;
    fe_set[SFSF_FE_AXIS_Y_BIT]    = i_axis_y_diag_fail;
    fe_set[SFSF_FE_AXIS_X_BIT]    = i_axis_x_diag_fail;
    fe_set[SFSF_FE_TRIM_BIT]      = i_trim_error;
    fe_set[SFSF_FE_REGULATOR_BIT] = i_regulator_fault_flag;
  end

  // system set terms; feedback compared two cycles after the drive request
  always_comb begin
    sys_set                        = '0;
    sys_set[SFSF_SYS_ATTN_DRV_BIT] = attn_drive_d2 && attention_pin_level;
    sys_set[SFSF_SYS_SOUT_DRV_BIT] = sout_en_d2 && (sout_val_d2 != serial_out_pin_sync);
    sys_set[SFSF_SYS_CHECK_BIT]    = i_check_code_error;
    sys_set[SFSF_SYS_FRAME_BIT]    = i_frame_error;
    sys_set[SFSF_SYS_OVER_BIT]     = i_supply_over && powered_active;
    sys_set[SFSF_SYS_UNDER_BIT]    = i_supply_under && powered_active;
    sys_set[SFSF_SYS_TEMP_LIM_BIT] = i_temp_limit_crossed;
    sys_set[SFSF_SYS_Z_LIM_BIT]    = i_z_field_limit_crossed;
    sys_set[SFSF_SYS_Y_LIM_BIT]    = i_y_field_limit_crossed;
    sys_set[SFSF_SYS_X_LIM_BIT]    = i_x_field_limit_crossed;
  end

  // a read clears exactly the flags it returned; a set in the same cycle wins
  always_comb begin
    fe_clear             = rd_fe ? front_end_flags : '0;
    sys_clear            = rd_sys ? system_flags : '0;
    next_front_end_flags = ((front_end_flags & ~fe_clear) | fe_set) & SFSF_FE_CLEAR_MASK;
    next_system_flags    = ((system_flags & ~sys_clear) | sys_set) & SFSF_SYS_CLEAR_MASK;
  end

  // flag storage; power-up flag comes out of reset set
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      front_end_flags <= SFSF_FRONT_END_RESET;
      system_flags    <= SFSF_SYSTEM_RESET;
    end else begin
      front_end_flags <= next_front_end_flags;
      system_flags    <= next_system_flags;
    end
  end

  // read views; reserved bits masked to zero
  always_comb begin
    fe_view  = front_end_flags & SFSF_FE_CLEAR_MASK;
    sys_view = system_flags & SFSF_SYS_CLEAR_MASK;
    sys_view[SFSF_SYS_PIN_LEVEL_BIT] = attention_pin_level;
    sys_view[SFSF_SYS_STATE_LSB +: 3] = i_operating_state;
  end

  // registered read data; unmapped addresses return zero
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data  <= '0;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_strobe;
      if (rd_fe) begin
        o_rd_data <= fe_view;
      end else if (rd_sys) begin
        o_rd_data <= sys_view;
      end else if (i_rd_strobe) begin
        o_rd_data <= '0;
      end
    end
  end

  // cause summary registered from the next flag values, so it changes on the same edge as the stored flags
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_attention_cause <= SFSF_CAUSE_FE;
    end else begin
      unique case ({|next_system_flags, |next_front_end_flags})
        2'b00: o_attention_cause <= SFSF_CAUSE_NONE;
        2'b01: o_attention_cause <= SFSF_CAUSE_FE;
        2'b10: o_attention_cause <= SFSF_CAUSE_SYS;
        2'b11: o_attention_cause <= SFSF_CAUSE_BOTH;
      endcase
    end
  end
endmodule : sfsf_status_bank

// ---- tb/sfsf_pin_model.sv ----
// pin model: pulled-up open-drain attention line and serial output feedback
`timescale 1ns/100ps
module sfsf_pin_model (
  input  wire logic i_mclk,
  input  wire logic i_attention_drive_low,
  input  wire logic i_attention_stuck,
  input  wire logic i_serial_out_enable,
  input  wire logic i_serial_out_value,
  input  wire logic i_serial_stuck,
  output logic      o_attention_pin_level,
  output logic      o_serial_out_pin
);
  logic last_value = 1'b0;
  // pull-up wins unless the line is pulled low; a stuck line never goes low
  assign o_attention_pin_level = !(i_attention_drive_low && !i_attention_stuck);
  // a released line shows the inverse of the last driven value, never a stale copy
  always_ff @(posedge i_mclk) if (i_serial_out_enable) last_value <= i_serial_out_value;
  assign o_serial_out_pin = i_serial_out_enable ? i_serial_out_value ^ i_serial_stuck : !last_value;
endmodule // sfsf_pin_model

// ---- tb/sfsf_chk.sv ----
// assertions on the fault status bank ports
`timescale 1ns/100ps
module sfsf_chk
  import sfsf_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic        i_rd_strobe,
  input wire logic [5:0]  i_rd_addr,
  input wire logic [15:0] o_rd_data,
  input wire logic        i_trim_error,
  input wire logic        i_check_code_error,
  input wire logic        i_x_field_limit_crossed,
  input wire logic        i_supply_over,
  input wire logic [2:0]  i_operating_state,
  input wire logic [1:0]  o_attention_cause
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // read strobes per register
  wire rd_fe = i_rd_strobe && i_rd_addr == SFSF_FRONT_END_OFFSET;
  wire rd_sy = i_rd_strobe && i_rd_addr == SFSF_SYSTEM_OFFSET;
  property p_fe_rsv; rd_fe |=> (o_rd_data & 16'h60FC) == 16'h0000; endproperty
  a_fe_rsv: assert property (p_fe_rsv) else $error("front-end reserved bits set");
  property p_sy_rsv; rd_sy |=> o_rd_data[7:6] == 2'h0; endproperty
  a_sy_rsv: assert property (p_sy_rsv) else $error("system reserved bits set");
  property p_state; rd_sy |=> o_rd_data[10:8] == $past(i_operating_state); endproperty
  a_state: assert property (p_state) else $error("state field wrong");
  property p_pwr_clr; rd_fe ##1 rd_fe |=> !o_rd_data[15]; endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("power-up flag kept");
  property p_trim; i_trim_error ##1 rd_fe |=> o_rd_data[1]; endproperty
  a_trim: assert property (p_trim) else $error("trim flag missing");
  property p_crc; i_check_code_error ##1 rd_sy |=> o_rd_data[12]; endproperty
  a_crc: assert property (p_crc) else $error("check-code flag missing");
  property p_xlim; i_x_field_limit_crossed ##1 rd_sy |=> o_rd_data[0]; endproperty
  a_xlim: assert property (p_xlim) else $error("x limit flag missing");
  property p_over;
    i_supply_over && i_operating_state inside {[3'h1:3'h4]} ##1 rd_sy |=> o_rd_data[5];
  endproperty
  a_over: assert property (p_over) else $error("over-voltage flag missing");
  property p_cause; i_check_code_error |=> o_attention_cause[1]; endproperty
  a_cause: assert property (p_cause) else $error("cause lacks system flag");
endmodule // sfsf_chk
bind sfsf_status_bank sfsf_chk chk_u (.*);

// ---- tb/sfsf_status_bank_bench.sv ----
// bench for the fault status bank: register reads after fault events
`timescale 1ns/100ps
module sfsf_status_bank_bench
  import sfsf_pkg::*;
  ;
  localparam int BITPOS [15] = '{12, 11, 10, 9, 8, 1, 0, 12, 11, 5, 4, 3, 2, 1, 0};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        strobe = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [14:0] ev = 15'h0000;
  logic [2:0]  st = 3'h0;
  logic        drv = 1'b0, astk = 1'b0, sen = 1'b0, sval = 1'b0, sstk = 1'b0;
  wire         apin, spin, rvalid;
  wire  [15:0] rdata;
  wire  [1:0]  cause;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  sfsf_status_bank dut_u (.i_mclk(clk), .i_arst_n(arst_n), .i_rd_strobe(strobe),
    .i_rd_addr(addr), .o_rd_data(rdata), .o_rd_valid(rvalid),
    .i_front_end_diag_fail(ev[0]), .i_temp_diag_fail(ev[1]), .i_axis_z_diag_fail(ev[2]),
    .i_axis_y_diag_fail(ev[3]), .i_axis_x_diag_fail(ev[4]), .i_trim_error(ev[5]),
    .i_regulator_fault_flag(ev[6]), .i_attention_drive_low(drv), .i_attention_pin_level(apin),
    .i_serial_out_enable(sen), .i_serial_out_value(sval), .i_serial_out_pin(spin),
    .i_check_code_error(ev[7]), .i_frame_error(ev[8]), .i_operating_state(st),
    .i_supply_over(ev[9]), .i_supply_under(ev[10]), .i_temp_limit_crossed(ev[11]),
    .i_z_field_limit_crossed(ev[12]), .i_y_field_limit_crossed(ev[13]),
    .i_x_field_limit_crossed(ev[14]), .o_attention_cause(cause));
  sfsf_pin_model pins_u (.i_mclk(clk), .i_attention_drive_low(drv), .i_attention_stuck(astk),
    .i_serial_out_enable(sen), .i_serial_out_value(sval), .i_serial_stuck(sstk),
    .o_attention_pin_level(apin), .o_serial_out_pin(spin));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  task end_of_test;
    $display("checked %0d values, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // strobe stays up so reads can run back to back; pulse drops it
  task rd(input logic [5:0] a, input logic [15:0] exp, input logic [14:0] e);
    strobe = 1'b1;
    addr = a;
    ev = e;
    @(negedge clk);
    check({15'h0000, rvalid}, 16'h0001);
    check(rdata, exp);
  endtask
  // events stay until the next call drives ev, so no double write in one step
  task pulse(input logic [14:0] e);
    strobe = 1'b0;
    ev = e;
    @(negedge clk);
  endtask
  function automatic logic [15:0] sysv(input logic [15:0] b);
    return 16'h8000 | {5'h00, st, 8'h00} | b;
  endfunction
  // hang guard, far above the roughly 130 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    check({14'h0000, cause}, {14'h0000, SFSF_CAUSE_FE});
    rd(SFSF_FRONT_END_OFFSET, SFSF_FRONT_END_RESET, '0);
    rd(SFSF_FRONT_END_OFFSET, 16'h0000, '0);
    rd(SFSF_SYSTEM_OFFSET, 16'h8000, '0);
    rd(6'h0F, 16'h0000, '0);
    pulse('0);
    check({14'h0000, cause}, {14'h0000, SFSF_CAUSE_NONE});
    st = SFSF_MODE_STANDBY;
    for (int i = 0; i < 15; i++) begin
      pulse(15'h0001 << i);
      check({14'h0000, cause}, (i < 7) ? 16'h0001 : 16'h0002);
      if (i < 7) begin
        rd(SFSF_FRONT_END_OFFSET, 16'h0001 << BITPOS[i], '0);
        rd(SFSF_FRONT_END_OFFSET, 16'h0000, '0);
      end else begin
        rd(SFSF_SYSTEM_OFFSET, sysv(16'h0001 << BITPOS[i]), '0);
        rd(SFSF_SYSTEM_OFFSET, sysv(16'h0000), '0);
      end
      pulse('0);
    end
    pulse(15'h0081);
    check({14'h0000, cause}, {14'h0000, SFSF_CAUSE_BOTH});
    st = SFSF_MODE_CONFIG;
    pulse(15'h0600);
    rd(SFSF_FRONT_END_OFFSET, 16'h1000, '0);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h1000), '0);
    for (int s = 0; s < 7; s++) begin
      st = s[2:0];
      rd(SFSF_SYSTEM_OFFSET, sysv(16'h0000), '0);
    end
    // supply events in sleep are ignored, in duty-cycled active they count
    pulse(15'h0600);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h0000), '0);
    st = SFSF_MODE_DUTY_ACT;
    pulse(15'h0600);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h0030), '0);
    pulse(15'h0020);
    rd(SFSF_FRONT_END_OFFSET, 16'h0002, 15'h0020);
    rd(SFSF_FRONT_END_OFFSET, 16'h0002, '0);
    rd(SFSF_FRONT_END_OFFSET, 16'h0000, '0);
    pulse('0);
    drv = 1'b1;
    repeat (4) @(negedge clk);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h0000) & 16'h7FFF, '0);
    pulse('0);
    {drv, astk} = 2'h3;
    repeat (4) @(negedge clk);
    drv = 1'b0;
    repeat (4) @(negedge clk);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h4000), '0);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h0000), '0);
    pulse('0);
    sen = 1'b1;
    for (int k = 0; k < 6; k++) begin
      sval = k[0];
      @(negedge clk);
    end
    sen = 1'b0;
    repeat (4) @(negedge clk);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h0000), '0);
    pulse('0);
    {sen, sstk} = 2'h3;
    repeat (3) @(negedge clk);
    {sen, sstk} = 2'h0;
    repeat (4) @(negedge clk);
    rd(SFSF_SYSTEM_OFFSET, sysv(16'h2000), '0);
    pulse('0);
    end_of_test;
  end
endmodule // sfsf_status_bank_bench
